//--- cpu_ctrl_model.sv
/* Model of the integer pipeline issuing control moves.
   Tasks are entered 1ns after a rising core_clk edge. */
`timescale 1ns/100ps
`default_nettype none
module cpu_ctrl_model (
    // Clock
    input  wire logic        core_clk,
    // Control moves
    output logic             ctrlRead,
    output logic             ctrlWrite,
    output logic [31:0]      ctrlWriteData,
    output logic             pipeBusy,
    input  wire logic        ctrlReadValid,
    input  wire logic        ctrlReadRetry,
    input  wire logic [31:0] ctrlReadData
);
    initial begin
        ctrlRead = 1'h0;
        ctrlWrite = 1'h0;
        ctrlWriteData = 32'h0;
        pipeBusy = 1'h0;
    end
    // Writes only with the pipeline drained
    task automatic wr(input logic [31:0] d);
        ctrlWrite = 1'h1;
        ctrlWriteData = d;
        @(posedge core_clk) #1;
        ctrlWrite = 1'h0;
        ctrlWriteData = ~d;
    endtask
    // Busy models unfinished ops still draining
    task automatic rd(input int busy, output logic [31:0] q, output logic retry);
        ctrlRead = 1'h1;
        if (busy > 0) pipeBusy = 1'h1;
        for (int i = 0; i < 40; i++) begin
            @(posedge core_clk) #1;
            if (i + 1 == busy) pipeBusy = 1'h0;
            if (ctrlReadValid === 1'h1 || ctrlReadRetry === 1'h1) break;
        end
        q = ctrlReadData;
        retry = ctrlReadRetry;
        ctrlRead = 1'h0;
    endtask
endmodule // cpu_ctrl_model
`default_nettype wire

//--- fp_class_decode.sv
/*
 * Combinational operand class decoder for single and double formats.
 * Assumes single operands sit in the low 32 bits.
 */
`timescale 1ns/100ps
`default_nettype none
module fp_class_decode (
    // Operand in, class out
    fp_class_if.decoder cls
);
    logic                           expAllOnes;
    logic                           expZero;
    logic                           fracZero;
    logic                           fracMsb;

    always_comb begin
        if (cls.isDouble) begin
            // 11-bit exponent; field max is Emax+1, zero is Emin-1
            expAllOnes = &cls.operand[62:52];
            expZero    = ~|cls.operand[62:52];
            fracZero   = ~|cls.operand[51:0];
            fracMsb    = cls.operand[51];
            cls.sign   = cls.operand[63];
        end else begin
            expAllOnes = &cls.operand[30:23];
            expZero    = ~|cls.operand[30:23];
            fracZero   = ~|cls.operand[22:0];
            fracMsb    = cls.operand[22];
            cls.sign   = cls.operand[31];
        end
        if (expAllOnes) begin
            if (fracZero) begin
                cls.opClass = fpu_csr_pkg::CLS_INFINITY;
            end else if (fracMsb) begin
                cls.opClass = fpu_csr_pkg::CLS_SIGNALING_NAN;
            end else begin
                cls.opClass = fpu_csr_pkg::CLS_QUIET_NAN;
            end
        end else if (expZero) begin
            cls.opClass = fracZero ? fpu_csr_pkg::CLS_ZERO
                                   : fpu_csr_pkg::CLS_DENORMAL;
        end else begin
            cls.opClass = fpu_csr_pkg::CLS_NORMAL;
        end
    end
endmodule // fp_class_decode
`default_nettype wire

//--- fp_class_if.sv
/*
 * Interface carrying one operand to the class decoder and its class back.
 * Assumes one combinational decoder on the far modport.
 */
`timescale 1ns/100ps
`default_nettype none
interface fp_class_if;
    logic [63:0]                 operand;
    logic                        isDouble;
    fpu_csr_pkg::operand_class_t opClass;
    logic                        sign;

    modport requester (output operand, output isDouble, input opClass, input sign);
    modport decoder   (input operand, input isDouble, output opClass, output sign);
endinterface
`default_nettype wire

//--- fpu_control_status.sv
/*
 * Floating-point control/status register with exception raising and
 * operand class decode. Assumes the pipeline reports each finished
 * operation as a one-cycle pulse and holds control moves until answered.
 */
`timescale 1ns/100ps
`default_nettype none
module fpu_control_status (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Control moves from the integer pipeline
    input  wire logic        ctrlRead,
    input  wire logic        ctrlWrite,
    input  wire logic [31:0] ctrlWriteData,
    input  wire logic        pipeBusy,
    output logic             ctrlReadValid,
    output logic [31:0]      ctrlReadData,
    output logic             ctrlReadRetry,
    // Finished arithmetic operation report
    input  wire logic        opDone,
    input  wire logic [4:0]  opIeeeExc,
    input  wire logic        opNeedsEmul,
    input  wire logic        opResultDenormal,
    input  wire logic        opFusedMulAdd,
    input  wire logic        opProductDenormal,
    // Compare report
    input  wire logic        cmpDone,
    input  wire logic [2:0]  cmpCondSel,
    input  wire logic        cmpTrue,
    // Operand classification
    input  wire logic [63:0] classOperand,
    input  wire logic        classDouble,
    output logic [2:0]       classResult,
    output logic             classSign,
    // Outcome to the pipeline and datapath
    output logic             fpException,
    output logic             resultWriteEnable,
    output logic             resultFlushZero,
    output logic [1:0]       roundingMode
);
    logic [1:0]  roundSel;
    logic [4:0]  flags;
    logic [4:0]  enables;
    logic [5:0]  cause;
    logic        flushDenorm;
    logic [7:0]  condBits;
    logic [1:0]  next_roundSel;
    logic [4:0]  next_flags;
    logic [4:0]  next_enables;
    logic [5:0]  next_cause;
    logic        next_flushDenorm;
    logic [7:0]  next_condBits;
    logic        next_fpException;
    logic        next_resultWriteEnable;
    logic        next_resultFlushZero;
    logic        next_ctrlReadValid;
    logic        next_ctrlReadRetry;
    logic [31:0] next_ctrlReadData;
    logic [2:0]  next_classResult;
    logic        next_classSign;
    logic [5:0]  opCause;
    logic        opUnimpl;
    logic        opTaken;
    logic [31:0] csrImage;

    fp_class_if clsBus ();

    fp_class_decode u_decode (
        .cls (clsBus.decoder)
    );

    assign clsBus.operand  = classOperand;
    assign clsBus.isDouble = classDouble;

    // Packs fields into the architected register image
    function automatic logic [31:0] pack_csr(input logic [7:0] cc, input logic fs,
                                             input logic [5:0] ca, input logic [4:0] en,
                                             input logic [4:0] fl, input logic [1:0] rm);
        logic [31:0] img;
        img = 32'h00000000;
        img[fpu_csr_pkg::CONDUP_LSB +: 7] = cc[7:1];
        img[fpu_csr_pkg::FLUSH_BIT]        = fs;
        img[fpu_csr_pkg::COND0_BIT]        = cc[0];
        img[fpu_csr_pkg::CAUSE_LSB +: 6]   = ca;
        img[fpu_csr_pkg::ENABLE_LSB +: 5]  = en;
        img[fpu_csr_pkg::FLAG_LSB +: 5]    = fl;
        img[fpu_csr_pkg::RM_LSB +: 2]      = rm;
        return img;
    endfunction

    // Raise test shared by operations and register writes
    function automatic logic raises(input logic [5:0] ca, input logic [4:0] en);
        return ca[5] | (|(ca[4:0] & en));
    endfunction

    assign csrImage = pack_csr(condBits, flushDenorm, cause, enables, flags, roundSel);

    always_comb begin
        // Denormal handling decides whether emulation is needed
        opUnimpl = opNeedsEmul
                 | (opFusedMulAdd & opProductDenormal)
                 | (opResultDenormal & ~flushDenorm);
        opCause  = {opUnimpl, opIeeeExc};
        opTaken  = raises(opCause, enables);

        next_roundSel          = roundSel;
        next_flags             = flags;
        next_enables           = enables;
        next_cause             = cause;
        next_flushDenorm       = flushDenorm;
        next_condBits          = condBits;
        next_fpException       = 1'b0;
        next_resultWriteEnable = 1'b0;
        next_resultFlushZero   = 1'b0;
        next_ctrlReadValid     = 1'b0;
        next_ctrlReadRetry     = 1'b0;
        next_ctrlReadData      = ctrlReadData;
        next_classResult       = clsBus.opClass;
        next_classSign         = clsBus.sign;

        if (opDone) begin
            next_cause = opCause;
            if (opTaken) begin
                next_fpException = 1'b1;
            end else begin
                next_resultWriteEnable = 1'b1;
                next_resultFlushZero   = opResultDenormal & flushDenorm;
                next_flags             = flags | opIeeeExc;
            end
        end

        if (cmpDone) begin
            next_condBits[cmpCondSel] = cmpTrue;
        end

        // Writes come only while idle; no privilege check exists
        if (ctrlWrite) begin
            next_condBits    = {ctrlWriteData[fpu_csr_pkg::CONDUP_LSB +: 7],
                                ctrlWriteData[fpu_csr_pkg::COND0_BIT]};
            next_flushDenorm = ctrlWriteData[fpu_csr_pkg::FLUSH_BIT];
            next_cause       = ctrlWriteData[fpu_csr_pkg::CAUSE_LSB +: 6];
            next_enables     = ctrlWriteData[fpu_csr_pkg::ENABLE_LSB +: 5];
            next_flags       = ctrlWriteData[fpu_csr_pkg::FLAG_LSB +: 5];
            next_roundSel    = ctrlWriteData[fpu_csr_pkg::RM_LSB +: 2];
            next_fpException = raises(ctrlWriteData[fpu_csr_pkg::CAUSE_LSB +: 6],
                                      ctrlWriteData[fpu_csr_pkg::ENABLE_LSB +: 5]);
        end

        // Read waits for the drain; a drain exception sends it back
        if (ctrlRead && !pipeBusy) begin
            if (opDone && opTaken) begin
                next_ctrlReadRetry = 1'b1;
            end else begin
                next_ctrlReadValid = 1'b1;
                next_ctrlReadData  = csrImage & fpu_csr_pkg::CSR_WRITE_MASK;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            roundSel          <= fpu_csr_pkg::CSR_RESET[1:0];
            flags             <= fpu_csr_pkg::CSR_RESET[6:2];
            enables           <= fpu_csr_pkg::CSR_RESET[11:7];
            cause             <= fpu_csr_pkg::CSR_RESET[17:12];
            flushDenorm       <= fpu_csr_pkg::CSR_RESET[24];
            condBits          <= 8'h00;
            fpException       <= 1'b0;
            resultWriteEnable <= 1'b0;
            resultFlushZero   <= 1'b0;
            ctrlReadValid     <= 1'b0;
            ctrlReadRetry     <= 1'b0;
            ctrlReadData      <= 32'h00000000;
            classResult       <= 3'h0;
            classSign         <= 1'b0;
            roundingMode      <= 2'h0;
        end else begin
            roundSel          <= next_roundSel;
            flags             <= next_flags;
            enables           <= next_enables;
            cause             <= next_cause;
            flushDenorm       <= next_flushDenorm;
            condBits          <= next_condBits;
            fpException       <= next_fpException;
            resultWriteEnable <= next_resultWriteEnable;
            resultFlushZero   <= next_resultFlushZero;
            ctrlReadValid     <= next_ctrlReadValid;
            ctrlReadRetry     <= next_ctrlReadRetry;
            ctrlReadData      <= next_ctrlReadData;
            classResult       <= 3'(next_classResult);
            classSign         <= next_classSign;
            roundingMode      <= next_roundSel;
        end
    end
endmodule // fpu_control_status
`default_nettype wire

//--- fpu_control_status_chk.sv
/* Concurrent checks on the ports of the control/status block.
   Assumes one clock, core_clk, and the asynchronous reset arst_n. */
`timescale 1ns/100ps
`default_nettype none
module fpu_control_status_chk (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        arst_n,
    // Control moves
    input wire logic        ctrlRead,
    input wire logic        ctrlWrite,
    input wire logic        pipeBusy,
    input wire logic [31:0] ctrlWriteData,
    input wire logic [31:0] ctrlReadData,
    input wire logic        ctrlReadValid,
    input wire logic        ctrlReadRetry,
    // Operation report
    input wire logic        opDone,
    input wire logic        opNeedsEmul,
    input wire logic        opResultDenormal,
    input wire logic        opFusedMulAdd,
    input wire logic        opProductDenormal,
    input wire logic [4:0]  opIeeeExc,
    // Outcome
    input wire logic        fpException,
    input wire logic        resultWriteEnable,
    input wire logic        resultFlushZero,
    input wire logic [1:0]  roundingMode
);
    // Shadow of controls that only writes change
    logic       flush, next_flush;
    logic [4:0] en, next_en;
    always_comb begin
        next_flush = ctrlWrite ? ctrlWriteData[24] : flush;
        next_en = ctrlWrite ? ctrlWriteData[11:7] : en;
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flush <= 1'h0;
            en <= 5'h0;
        end else begin
            flush <= next_flush;
            en <= next_en;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_op;
        opDone && !ctrlWrite;
    endsequence
    sequence s_emul;
        s_op ##0 (opNeedsEmul || opFusedMulAdd && opProductDenormal
            || opResultDenormal && !flush);
    endsequence
    sequence s_trap;
        fpException && !resultWriteEnable;
    endsequence
    a_read_answer: assert property (ctrlRead && !pipeBusy && !ctrlReadValid && !ctrlReadRetry
        |=> ctrlReadValid || ctrlReadRetry)
        else $error("read not answered");
    a_busy_hold: assert property (ctrlRead && pipeBusy |=> !ctrlReadValid)
        else $error("read answered while busy");
    a_unimpl_trap: assert property (s_emul |=> s_trap)
        else $error("emulation case not trapped");
    a_enabled_trap: assert property (s_op ##0 (|(opIeeeExc & en)) |=> s_trap)
        else $error("enabled cause not trapped");
    a_default_store: assert property (s_op ##0 !opNeedsEmul && !opResultDenormal
        && !(opFusedMulAdd && opProductDenormal) && (opIeeeExc & en) == 5'h0
        |=> resultWriteEnable && !fpException && !resultFlushZero)
        else $error("default result not stored");
    a_flush_store: assert property (s_op ##0 opResultDenormal && flush
        && !opNeedsEmul && !opFusedMulAdd && (opIeeeExc & en) == 5'h0
        |=> resultWriteEnable && resultFlushZero && !fpException)
        else $error("denormal result not flushed");
    a_write_trap: assert property (ctrlWrite && (ctrlWriteData[17]
        || |(ctrlWriteData[16:12] & ctrlWriteData[11:7])) |=> fpException)
        else $error("written cause not trapped");
    a_round_follow: assert property (ctrlWrite |=> roundingMode == $past(ctrlWriteData[1:0]))
        else $error("rounding mode not updated");
    a_spare_zero: assert property (ctrlReadValid |-> ctrlReadData[22:18] == 5'h00)
        else $error("unassigned bit reads one");
endmodule // fpu_control_status_chk
bind fpu_control_status fpu_control_status_chk chk (
    .core_clk          (core_clk),
    .arst_n            (arst_n),
    .ctrlRead          (ctrlRead),
    .ctrlWrite         (ctrlWrite),
    .pipeBusy          (pipeBusy),
    .ctrlWriteData     (ctrlWriteData),
    .ctrlReadData      (ctrlReadData),
    .ctrlReadValid     (ctrlReadValid),
    .ctrlReadRetry     (ctrlReadRetry),
    .opDone            (opDone),
    .opNeedsEmul       (opNeedsEmul),
    .opResultDenormal  (opResultDenormal),
    .opFusedMulAdd     (opFusedMulAdd),
    .opProductDenormal (opProductDenormal),
    .opIeeeExc         (opIeeeExc),
    .fpException       (fpException),
    .resultWriteEnable (resultWriteEnable),
    .resultFlushZero   (resultFlushZero),
    .roundingMode      (roundingMode)
);
`default_nettype wire

//--- fpu_control_status_test.sv
/* Self-checking bench for the control/status block.
   Control moves come from cpu_ctrl_model; ops, compares, operands from here. */
`timescale 1ns/100ps
`default_nettype none
module fpu_control_status_test;
    logic        core_clk, arst_n;
    logic        ctrlRead, ctrlWrite, pipeBusy, ctrlReadValid, ctrlReadRetry, r;
    logic [31:0] ctrlWriteData, ctrlReadData, q;
    logic        opDone, opNeedsEmul, opResultDenormal, opFusedMulAdd, opProductDenormal;
    logic [4:0]  opIeeeExc;
    logic        cmpDone, cmpTrue, classDouble, classSign;
    logic        fpException, resultWriteEnable, resultFlushZero;
    logic [2:0]  cmpCondSel, classResult;
    logic [63:0] classOperand;
    logic [1:0]  roundingMode;
    int          numErrors = 0, totalChecks = 0, cycles = 0;
    fpu_control_status uut (
        .core_clk          (core_clk),
        .arst_n            (arst_n),
        .ctrlRead          (ctrlRead),
        .ctrlWrite         (ctrlWrite),
        .ctrlWriteData     (ctrlWriteData),
        .pipeBusy          (pipeBusy),
        .ctrlReadValid     (ctrlReadValid),
        .ctrlReadData      (ctrlReadData),
        .ctrlReadRetry     (ctrlReadRetry),
        .opDone            (opDone),
        .opIeeeExc         (opIeeeExc),
        .opNeedsEmul       (opNeedsEmul),
        .opResultDenormal  (opResultDenormal),
        .opFusedMulAdd     (opFusedMulAdd),
        .opProductDenormal (opProductDenormal),
        .cmpDone           (cmpDone),
        .cmpCondSel        (cmpCondSel),
        .cmpTrue           (cmpTrue),
        .classOperand      (classOperand),
        .classDouble       (classDouble),
        .classResult       (classResult),
        .classSign         (classSign),
        .fpException       (fpException),
        .resultWriteEnable (resultWriteEnable),
        .resultFlushZero   (resultFlushZero),
        .roundingMode      (roundingMode)
    );
    cpu_ctrl_model cpu (
        .core_clk      (core_clk),
        .ctrlRead      (ctrlRead),
        .ctrlWrite     (ctrlWrite),
        .ctrlWriteData (ctrlWriteData),
        .pipeBusy      (pipeBusy),
        .ctrlReadValid (ctrlReadValid),
        .ctrlReadRetry (ctrlReadRetry),
        .ctrlReadData  (ctrlReadData)
    );
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles >= 3000) begin
            numErrors++;
            endSim();
        end
    end
    task automatic endSim;
        if (numErrors == 0 && totalChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rdChk(input logic [31:0] exp);
        cpu.rd(0, q, r);
        chk("register", q, exp);
    endtask
    // Flags are {emul, result denormal, fused, product denormal}; x is {trap, store, flush}
    task automatic op(input logic [4:0] e, input logic [3:0] f, input logic [2:0] x);
        opDone = 1'h1;
        opIeeeExc = e;
        {opNeedsEmul, opResultDenormal, opFusedMulAdd, opProductDenormal} = f;
        @(posedge core_clk) #1;
        opDone = 1'h0;
        chk("outcome", {fpException, resultWriteEnable, resultFlushZero}, x);
        @(posedge core_clk) #1;
    endtask
    task automatic cmp(input int s, input logic t);
        cmpDone = 1'h1;
        cmpCondSel = s[2:0];
        cmpTrue = t;
        @(posedge core_clk) #1;
        cmpDone = 1'h0;
        @(posedge core_clk) #1;
    endtask
    task automatic tRegs;
        rdChk(32'h0);
        cpu.wr(32'hffffffff);
        chk("writeTrap", fpException, 1'h1);
        rdChk(32'hff83ffff);
        for (int m = 0; m < 4; m++) begin
            cpu.wr(m);
            chk("round", roundingMode, m);
            // Strobe must drop for an edge between writes
            @(posedge core_clk) #1;
        end
    endtask
    task automatic tOps;
        cpu.wr(32'h0);
        op(5'h1f, 4'h0, 3'h2);
        rdChk(32'h0001f07c);
        op(5'h00, 4'h0, 3'h2);
        rdChk(32'h0000007c);
        cpu.wr(32'h00000200);
        op(5'h05, 4'h0, 3'h4);
        rdChk(32'h00005200);
        cpu.wr(32'h0);
        op(5'h00, 4'h8, 3'h4);
        rdChk(32'h00020000);
        cpu.wr(32'h01000000);
        op(5'h00, 4'h4, 3'h3);
        op(5'h00, 4'h7, 3'h4);
        rdChk(32'h01020000);
    endtask
    task automatic tCmp;
        cpu.wr(32'h0);
        for (int s = 0; s < 8; s++) cmp(s, 1'h1);
        op(5'h01, 4'h0, 3'h2);
        rdChk(32'hfe801004);
        cmp(3, 1'h0);
        rdChk(32'hf6801004);
    endtask
    task automatic tBusy;
        @(posedge core_clk) #1;
        cpu.rd(3, q, r);
        chk("drainRead", {r, q}, {1'h0, 32'hf6801004});
        cpu.wr(32'h00000080);
        fork
            cpu.rd(0, q, r);
            op(5'h01, 4'h0, 3'h4);
        join
        chk("retry", r, 1'h1);
        cpu.wr(32'h0);
        rdChk(32'h0);
    endtask
    task automatic tClass;
        logic [63:0] v [12] = '{64'h80000000, 64'h1, 64'h00800000, 64'h7f800000,
            64'h7fc00000, 64'h7f800001, 64'h8000000000000000, 64'h0008000000000000,
            64'h0010000000000000,
            64'h7ff0000000000000, 64'h7ff8000000000000, 64'h7ff0000000000001};
        for (int i = 0; i < 12; i++) begin
            classOperand = v[i];
            classDouble = i > 5;
            @(posedge core_clk) #1;
            chk("class", classResult, i % 6);
            chk("sign", classSign, i == 0 || i == 6);
        end
    endtask
    initial begin
        core_clk = 1'h0;
        arst_n = 1'h0;
        {opDone, opNeedsEmul, opResultDenormal, opFusedMulAdd, opProductDenormal} = 5'h00;
        {cmpDone, cmpTrue, classDouble} = 3'h0;
        opIeeeExc = 5'h00;
        cmpCondSel = 3'h0;
        classOperand = 64'h0;
        repeat (12) @(posedge core_clk);
        #1 arst_n = 1'h1;
        tRegs();
        tOps();
        tCmp();
        tBusy();
        tClass();
        endSim();
    end
endmodule // fpu_control_status_test
`default_nettype wire

//--- fpu_csr_pkg.sv
/*
 * Constants and types for the floating-point control/status block.
 * Assumes the CPU pipeline drives the control-move and operation-completion ports.
 */
// Behaviour
// - Flush bit zeroes denormal results, no exception
// - Fused multiply-add denormal product always unimplemented
// - Compare writes selected condition bit
// - Condition bits change only on compare/write
// - Cause shows all exceptions of last op
// - Arithmetic rewrites cause; moves leave it (a control write loads cause from the write data)
// - Unimplemented cause set only when emulation needed
// - Taken exception stores no result, cause only
// - Cause and enable both set raise exception
// - Unimplemented cause always raises exception
// - Unenabled causes store default result, no exception
// - Flags sticky; only writes clear them
// - Taken exception does not update flags
// - Two-bit field selects rounding mode
// - Read drains pipeline; exception forces re-execution
// - Register accessible in kernel and user mode
// - Single: 8-bit exponent, bias 127
// - Double: 11-bit exponent, bias 1023
// - Extreme exponents decode NaN/inf/denormal/zero
// - NaN fraction MSB one means signaling
package fpu_csr_pkg;

    // Register layout
    localparam int RM_LSB        = 0;
    localparam int FLAG_LSB      = 2;
    localparam int ENABLE_LSB    = 7;
    localparam int CAUSE_LSB     = 12;
    localparam int UNIMPL_BIT    = 17;
    localparam int COND0_BIT     = 23;
    localparam int FLUSH_BIT     = 24;
    localparam int CONDUP_LSB    = 25;
    localparam logic [31:0] CSR_WRITE_MASK = 32'hffbfffff;
    localparam logic [31:0] CSR_RESET      = 32'h00000000;

    // IEEE exception bit order within cause/enable/flag: I U O Z V
    localparam int EXC_INEXACT   = 0;
    localparam int EXC_UNDERFLOW = 1;
    localparam int EXC_OVERFLOW  = 2;
    localparam int EXC_DIVZERO   = 3;
    localparam int EXC_INVALID   = 4;

    // Single format
    localparam int SGL_EXP_W     = 8;
    localparam int SGL_FRAC_W    = 23;
    localparam int SGL_BIAS      = 127;
    localparam int SGL_EMAX      = 127;
    localparam int SGL_EMIN      = -126;
    // Double format
    localparam int DBL_EXP_W     = 11;
    localparam int DBL_FRAC_W    = 52;
    localparam int DBL_BIAS      = 1023;
    localparam int DBL_EMAX      = 1023;
    localparam int DBL_EMIN      = -1022;

    typedef enum logic [1:0] {
        round_nearest_even    = 2'h0,
        round_toward_zero     = 2'h1,
        round_toward_plus_inf = 2'h2,
        round_toward_minus_inf = 2'h3
    } round_mode_t;

    typedef enum logic [2:0] {
        CLS_ZERO,
        CLS_DENORMAL,
        CLS_NORMAL,
        CLS_INFINITY,
        CLS_SIGNALING_NAN,
        CLS_QUIET_NAN
    } operand_class_t;

endpackage
